// ---- hdl/acs_regs.vh ----
// Register indices, field positions, reset values and timing counts.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define ACS_IDX_RES_HI     8'h1e
`define ACS_IDX_CTRL0      8'h1f
`define ACS_IDX_FLAGS      8'h0c
`define ACS_IDX_IRQ_EN     8'h8c
`define ACS_IDX_ANALOG_PIN_SELECT      8'h91
`define ACS_IDX_RES_LO     8'h9e
`define ACS_IDX_CLK_SEL    8'h9f

// Converter control zero fields.
`define ACS_C0_JUST        7
`define ACS_C0_REF         6
`define ACS_C0_CHS_HI      4
`define ACS_C0_CHS_LO      2
`define ACS_C0_GO          1
`define ACS_C0_ON          0

// Conversion clock select field and flag positions.
`define ACS_C1_CLK_HI      6
`define ACS_C1_CLK_LO      4
`define ACS_FLAG_DONE      6
`define ACS_IE_DONE        6

// Reset values.
`define ACS_RST_CTRL0      8'h00
`define ACS_RST_CLK_SEL    3'h0
`define ACS_RST_ANALOG_PIN_SELECT      8'hff

// Timing in conversion clock periods, system clocks and nanoseconds.
`define ACS_CONV_TADS      4'hb
`define ACS_ABORT_TADS     4'h2
`define ACS_CLK_PER_INSTR  4'h4
`define ACS_MIN_TAD_NS     1600

`endif

// ---- hdl/acs_sequencer.v ----
// Conversion sequencer of a 10-bit converter with an AXI4-Lite slave.
// How it works
// - Clock field picks divide-by or RC clock.
// - A conversion lasts eleven conversion clocks.
// - Writing status bit one starts a conversion.
// - Done clears status, sets flag, raises interrupt.
// - Clearing status aborts; result keeps old value.
// - After abort wait two clocks, then acquire.
// - Justification bit picks right or left format.
// - Left: high holds eight bits; right: two.
// - Reference bit picks external pin or supply.
// - Channel field routes input zero to seven.
// - Unimplemented control bits always read as zero.
// - Analog select bits mark pins analog, reset one.
// - Analog pins lose input, pull-up, change detect.
// - RC clock delays start by one instruction.
// - RC conversion done in sleep wakes if enabled.
// - Done in sleep, interrupt off: power down.
// - Non-RC clock: sleep aborts and powers down.
// - Reset turns off, aborts, keeps the result.
`include "acs_regs.vh"
`default_nettype none
module acs_sequencer #(
  parameter ADDR_W = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              sleep_mode,
  input  wire              rc_osc_clk,
  input  wire [9:0]        conv_result,
  output wire              conv_power,
  output wire [2:0]        conv_channel,
  output wire              conv_ref_ext,
  output wire              conv_sampling,
  output wire              conv_step,
  output wire              conversion_irq,
  output reg               wake_pulse,
  output wire [7:0]        pin_digital_in_off,
  output wire [7:0]        pin_pullup_off,
  output wire [7:0]        pin_change_det_off
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_DELAY = 4'b0010;
  localparam [3:0] ST_CONV  = 4'b0100;
  localparam [3:0] ST_ABORT = 4'b1000;
  localparam [2:0] SEL_NONE  = 3'h0;
  localparam [2:0] SEL_C0    = 3'h1;
  localparam [2:0] SEL_C1    = 3'h2;
  localparam [2:0] SEL_ANALOG_PIN_SELECT = 3'h3;
  localparam [2:0] SEL_RESH  = 3'h4;
  localparam [2:0] SEL_RESL  = 3'h5;
  localparam [2:0] SEL_FLAGS = 3'h6;
  localparam [2:0] SEL_IE    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////

  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_CTRL0, 2'b00})
        reg_sel = SEL_C0;
      else if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_CLK_SEL, 2'b00})
        reg_sel = SEL_C1;
      else if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_ANALOG_PIN_SELECT, 2'b00})
        reg_sel = SEL_ANALOG_PIN_SELECT;
      else if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_RES_HI, 2'b00})
        reg_sel = SEL_RESH;
      else if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_RES_LO, 2'b00})
        reg_sel = SEL_RESL;
      else if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_FLAGS, 2'b00})
        reg_sel = SEL_FLAGS;
      else if (addr == {{(ADDR_W-10){1'b0}}, `ACS_IDX_IRQ_EN, 2'b00})
        reg_sel = SEL_IE;
      else
        reg_sel = SEL_NONE;
    end
  endfunction
  // Last count of the system clock divider for each clock field code.
  function [5:0] tad_last;
    input [2:0] code;
    begin
      case (code)
        3'b000:  tad_last = 6'h01;
        3'b100:  tad_last = 6'h03;
        3'b001:  tad_last = 6'h07;
        3'b101:  tad_last = 6'h0f;
        3'b010:  tad_last = 6'h1f;
        3'b110:  tad_last = 6'h3f;
        default: tad_last = 6'h01;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  reg        just_r;
  reg        ref_r;
  reg  [2:0] chs_r;
  reg        on_r;
  reg  [2:0] clk_r;
  reg  [7:0] analog_pin_select_r;
  reg        done_r;
  reg        ie_r;
  reg  [9:0] res_r;
  reg  [3:0] state_r;
  reg  [5:0] div_r;
  reg  [3:0] cnt_r;
  reg        pd_r;
  reg        rc_s1_r;
  reg        rc_s2_r;
  reg        rc_s3_r;
  wire       wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire [2:0] wr_sel = reg_sel(s_axi_awaddr);
  wire       wr_en  = wr_go & s_axi_wstrb[0];
  wire [7:0] wd     = s_axi_wdata[7:0];
  wire       wr_c0  = wr_en & (wr_sel == SEL_C0);
  wire       rc_sel  = (clk_r[1:0] == 2'b11);
  wire       rc_edge = rc_s2_r & ~rc_s3_r;
  wire       tad_tick = rc_sel ? rc_edge : (div_r == tad_last(clk_r));
  wire       busy    = (state_r == ST_DELAY) | (state_r == ST_CONV);
  wire       last_tad = tad_tick & (cnt_r == `ACS_CONV_TADS - 4'h1);
  // A start needs the converter already on before this write.
  wire       start   = wr_c0 & wd[`ACS_C0_GO] & wd[`ACS_C0_ON] & on_r
                       & (state_r == ST_IDLE) & ~pd_r;
  wire       sw_abort = wr_c0 & busy & ~wd[`ACS_C0_GO];
  wire       sw_off   = wr_c0 & ~wd[`ACS_C0_ON];
  wire       sleep_abort = (state_r == ST_CONV) & sleep_mode & ~rc_sel;
  wire       conv_done = (state_r == ST_CONV) & last_tad & ~sw_abort
                         & ~sw_off & ~sleep_abort;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers. The result pair is left out of reset on purpose.
  always @(posedge aclk) begin
    if (!aresetn) begin
      just_r  <= 1'b0;
      ref_r   <= 1'b0;
      chs_r   <= 3'h0;
      on_r    <= 1'b0;
      clk_r   <= `ACS_RST_CLK_SEL;
      analog_pin_select_r <= `ACS_RST_ANALOG_PIN_SELECT;
      ie_r    <= 1'b0;
    end else if (wr_en) begin
      if (wr_sel == SEL_C0) begin
        just_r <= wd[`ACS_C0_JUST];
        ref_r  <= wd[`ACS_C0_REF];
        chs_r  <= wd[`ACS_C0_CHS_HI:`ACS_C0_CHS_LO];
        on_r   <= wd[`ACS_C0_ON];
      end else if (wr_sel == SEL_C1) begin
        clk_r <= wd[`ACS_C1_CLK_HI:`ACS_C1_CLK_LO];
      end else if (wr_sel == SEL_ANALOG_PIN_SELECT) begin
        analog_pin_select_r <= wd;
      end else if (wr_sel == SEL_IE) begin
        ie_r <= wd[`ACS_IE_DONE];
      end
    end
  end
  // Completion flag: a hardware set wins over a software clear.
  always @(posedge aclk) begin
    if (!aresetn)
      done_r <= 1'b0;
    else if (conv_done)
      done_r <= 1'b1;
    else if (wr_en && wr_sel == SEL_FLAGS)
      done_r <= wd[`ACS_FLAG_DONE];
  end
  always @(posedge aclk) begin
    if (conv_done)
      res_r <= conv_result;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The RC clock is foreign, so it is synchronised before edge detection.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_osc_clk;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end
  // Divider restarts on each start so the first period is whole.
  always @(posedge aclk) begin
    if (!aresetn || start || div_r == tad_last(clk_r))
      div_r <= 6'h00;
    else
      div_r <= div_r + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 4'h0;
      pd_r       <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (!sleep_mode)
        pd_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 4'h0;
          if (start)
            state_r <= rc_sel ? ST_DELAY : ST_CONV;
        end
        ST_DELAY: begin
          // One instruction lets a sleep instruction run first.
          if (sw_off) begin
            state_r <= ST_IDLE;
          end else if (sw_abort) begin
            state_r <= ST_ABORT;
            cnt_r   <= 4'h0;
          end else if (cnt_r == `ACS_CLK_PER_INSTR - 4'h1) begin
            state_r <= ST_CONV;
            cnt_r   <= 4'h0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_CONV: begin
          if (sw_off) begin
            state_r <= ST_IDLE;
          end else if (sleep_abort) begin
            state_r <= ST_IDLE;
            pd_r    <= 1'b1;
          end else if (sw_abort) begin
            state_r <= ST_ABORT;
            cnt_r   <= 4'h0;
          end else if (conv_done) begin
            state_r <= ST_IDLE;
            if (sleep_mode && ie_r)
              wake_pulse <= 1'b1;
            if (sleep_mode && !ie_r)
              pd_r <= 1'b1;
          end else if (tad_tick) begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_ABORT: begin
          if (sw_off) begin
            state_r <= ST_IDLE;
          end else if (tad_tick) begin
            // The first tick only aligns, so two whole periods follow it.
            if (cnt_r == `ACS_ABORT_TADS)
              state_r <= ST_IDLE;
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter and pin controls.
  assign conv_power    = on_r & ~pd_r;
  assign conv_channel  = chs_r;
  assign conv_ref_ext  = ref_r;
  // Sampling resumes by itself once the abort wait is over.
  assign conv_sampling = conv_power & (state_r == ST_IDLE);
  assign conv_step     = (state_r == ST_CONV) & tad_tick;
  assign conversion_irq = done_r & ie_r;
  assign pin_digital_in_off = analog_pin_select_r;
  assign pin_pullup_off     = analog_pin_select_r;
  assign pin_change_det_off = analog_pin_select_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data are taken in the same cycle.
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == SEL_NONE) ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  reg [7:0] rd_byte;
  always @* begin
    case (reg_sel(s_axi_araddr))
      SEL_C0:    rd_byte = {just_r, ref_r, 1'b0, chs_r, busy, on_r};
      SEL_C1:    rd_byte = {1'b0, clk_r, 4'h0};
      SEL_ANALOG_PIN_SELECT: rd_byte = analog_pin_select_r;
      SEL_RESH:  rd_byte = just_r ? {6'h00, res_r[9:8]} : res_r[9:2];
      SEL_RESL:  rd_byte = just_r ? res_r[7:0] : {res_r[1:0], 6'h00};
      SEL_FLAGS: rd_byte = {1'b0, done_r, 6'h00};
      SEL_IE:    rd_byte = {1'b0, ie_r, 6'h00};
      default:   rd_byte = 8'h00;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= (reg_sel(s_axi_araddr) == SEL_NONE) ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // acs_sequencer
`default_nettype wire

// ---- verification/acs_core_model.sv ----
// Behavioural converter core and RC oscillator facing the sequencer.
`default_nettype none
module acs_core_model (
  input  wire logic       aclk,
  input  wire logic       conv_power,
  // The chosen pin is only sensed here; its output driver stays off.
  input  wire logic [2:0] conv_channel,
  input  wire logic       conv_ref_ext,
  output var  logic [9:0] conv_result,
  output var  logic       rc_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tgl_r = 1'b0;
  // The oscillator runs free, unrelated in phase to the system clock.
  // A 1.6 us period keeps the RC conversion clock at its minimum period.
  initial begin
    rc_osc_clk = 1'b0;
    forever #800 rc_osc_clk = ~rc_osc_clk;
  end
  always @(posedge aclk) tgl_r <= ~tgl_r;
  // Unpowered, the core output is meaningless, so it churns every cycle.
  always_comb conv_result = conv_power ?
    {conv_channel, conv_ref_ext, 6'h2b} : {10{tgl_r}};
endmodule // acs_core_model
`default_nettype wire

// ---- verification/acs_seq_asserts.sv ----
// Concurrent checks on the conversion sequencer's ports.
`default_nettype none
module acs_seq_asserts #(
  parameter ADDR_W = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              sleep_mode,
  input wire logic              conv_power,
  input wire logic              conv_sampling,
  input wire logic              conv_step,
  input wire logic              wake_pulse,
  input wire logic [7:0]        pin_digital_in_off,
  input wire logic [7:0]        pin_pullup_off,
  input wire logic [7:0]        pin_change_det_off
);
  logic [3:0] steps_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // The count clears while acquiring, so it spans one conversion only.
  always_ff @(posedge aclk)
    if (!aresetn || conv_sampling) steps_r <= 4'h0;
    else if (conv_step) steps_r <= steps_r + 4'h1;
  ////////////////////////////////////////////////////////////////////////////
  property p_pins;
    pin_digital_in_off == pin_pullup_off &&
    pin_pullup_off == pin_change_det_off;
  endproperty
  a_pins: assert property (p_pins) else $error("pin controls differ");
  property p_step_pwr;
    conv_step |-> conv_power && !conv_sampling;
  endproperty
  a_step_pwr: assert property (p_step_pwr) else $error("step unpowered");
  property p_samp_pwr;
    conv_sampling |-> conv_power;
  endproperty
  a_samp_pwr: assert property (p_samp_pwr) else $error("sampling off");
  property p_step_max;
    conv_step |-> steps_r < 4'd11;
  endproperty
  a_step_max: assert property (p_step_max) else $error("too many steps");
  property p_wake;
    wake_pulse |-> sleep_mode ##1 !wake_pulse;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_slp;
    sleep_mode && !conv_power |=> !conv_power;
  endproperty
  a_slp: assert property (p_slp) else $error("woke in sleep");
  property p_rd_c0;
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == 12'h07c
      |-> !s_axi_rdata[5];
  endproperty
  a_rd_c0: assert property (p_rd_c0) else $error("bit five set");
  property p_rst;
    $rose(aresetn) |-> !conv_power && pin_pullup_off == 8'hff;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  c_conv: cover property (steps_r == 4'd11);
  c_wake: cover property (wake_pulse);
  c_slp: cover property (sleep_mode && $fell(conv_power));
endmodule // acs_seq_asserts
bind acs_sequencer acs_seq_asserts #(.ADDR_W(ADDR_W)) acs_seq_asserts_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .sleep_mode(sleep_mode), .conv_power(conv_power),
  .conv_sampling(conv_sampling), .conv_step(conv_step),
  .wake_pulse(wake_pulse), .pin_digital_in_off(pin_digital_in_off),
  .pin_pullup_off(pin_pullup_off), .pin_change_det_off(pin_change_det_off));
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the conversion sequencer.
`include "acs_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PIN_SEL = 8'h91;
  logic        aclk, aresetn, awv, wv, arv, sleep_mode, awrdy, wrdy;
  logic        bvalid, arrdy, rvalid, rc_clk, pwr, ref_ext, samp;
  logic        step, irq, wake;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [9:0]  res, ex;
  logic [7:0]  din, pup, chg;
  logic [2:0]  chan;
  logic [1:0]  bresp, rresp, resp;
  int          num_errors, comparisons, cyc, nstep, gap, last, n;
  acs_sequencer acs_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .sleep_mode(sleep_mode), .rc_osc_clk(rc_clk),
    .conv_result(res), .conv_power(pwr), .conv_channel(chan),
    .conv_ref_ext(ref_ext), .conv_sampling(samp), .conv_step(step),
    .conversion_irq(irq), .wake_pulse(wake), .pin_digital_in_off(din),
    .pin_pullup_off(pup), .pin_change_det_off(chg));
  acs_core_model acs_core_model_i (
    .aclk(aclk), .conv_power(pwr), .conv_channel(chan),
    .conv_ref_ext(ref_ext), .conv_result(res), .rc_osc_clk(rc_clk));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (step) begin
      nstep <= nstep + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input [7:0] i, input [7:0] d);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do @(posedge aclk); while (!(awrdy && wrdy));
    awv <= 1'b0;
    wv <= 1'b0;
    while (!bvalid) @(posedge aclk);
    resp = bresp;
  endtask
  task automatic rd(input [7:0] i);
    araddr <= {2'b00, i, 2'b00};
    arv <= 1'b1;
    do @(posedge aclk); while (!arrdy);
    arv <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd_v = rdata;
    resp = rresp;
  endtask
  // Channel is set first so the sampler settles before the start.
  task automatic start(input j, r, input [2:0] ch);
    wr(`ACS_IDX_CTRL0, {j, r, 1'b0, ch, 2'b01});
    repeat (40) @(posedge aclk);
    nstep = 0;
    wr(`ACS_IDX_CTRL0, {j, r, 1'b0, ch, 2'b11});
  endtask
  task automatic steps(input int k);
    while (nstep < k) @(posedge aclk);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awv, wv, arv, sleep_mode, awaddr, araddr, wdata} = '0;
    {num_errors, comparisons, cyc, nstep, gap, last} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ACS_IDX_CTRL0); chk(rd_v, `ACS_RST_CTRL0);
    rd(PIN_SEL); chk(rd_v, 32'hff);
    rd(8'h00);
    chk(resp, 2'b10);
    chk(rd_v, 32'h0);
    wr(8'h00, 8'h00);
    chk(resp, 2'b10);
    wr(`ACS_IDX_CLK_SEL, 8'hff); rd(`ACS_IDX_CLK_SEL); chk(rd_v, 32'h70);
    wr(`ACS_IDX_CTRL0, 8'hff); rd(`ACS_IDX_CTRL0); chk(rd_v, 32'hdd);
    chk({chan, ref_ext}, 4'hf);
    wr(PIN_SEL, 8'h5a); chk({din, pup, chg}, 24'h5a5a5a);
    chk(resp, 2'b00);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      wr(`ACS_IDX_CLK_SEL, {1'b0, i[0], i[2:1], 4'h0});
      start(i[0], i[1], i[2:0]);
      steps(11);
      repeat (3) @(posedge aclk);
      chk(gap, 2 << i);
      chk(nstep, 11);
      rd(`ACS_IDX_CTRL0); chk(rd_v[1], 1'b0);
      rd(`ACS_IDX_FLAGS); chk(rd_v[6], 1'b1);
      ex = {i[2:0], i[1], 6'h2b};
      rd(`ACS_IDX_RES_HI); chk(rd_v, i[0] ? ex[9:8] : ex[9:2]);
      rd(`ACS_IDX_RES_LO); chk(rd_v, i[0] ? ex[7:0] : ex[1:0] << 6);
      wr(`ACS_IDX_FLAGS, 8'h00);
    end
    $display("conversions done");
    wr(`ACS_IDX_CLK_SEL, 8'h10);
    start(1'b0, 1'b0, 3'h2);
    steps(3);
    wr(`ACS_IDX_CTRL0, 8'h09);
    chk(samp, 1'b0);
    n = 0;
    while (!samp && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(n >= 15 && n <= 26, 1'b1);
    rd(`ACS_IDX_RES_HI); chk(rd_v, 32'haa);
    rd(`ACS_IDX_FLAGS); chk(rd_v[6], 1'b0);
    start(1'b0, 1'b0, 3'h2);
    steps(2);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(pwr, 1'b0);
    rd(`ACS_IDX_CTRL0); chk(rd_v[1:0], 2'b01);
    sleep_mode <= 1'b0;
    $display("abort done");
    wr(`ACS_IDX_CLK_SEL, 8'h30);
    wr(`ACS_IDX_IRQ_EN, 8'h40);
    start(1'b0, 1'b0, 3'h2);
    sleep_mode <= 1'b1;
    n = 0;
    while (!step) begin
      @(posedge aclk);
      n++;
    end
    chk(n >= 3, 1'b1);
    while (!wake) @(posedge aclk);
    sleep_mode <= 1'b0;
    rd(`ACS_IDX_CTRL0); chk(rd_v[1:0], 2'b01);
    chk({irq, nstep[3:0]}, 5'h1b);
    rd(`ACS_IDX_RES_HI); chk(rd_v, 32'h4a);
    wr(`ACS_IDX_FLAGS, 8'h00); chk(irq, 1'b0);
    wr(`ACS_IDX_IRQ_EN, 8'h00);
    start(1'b0, 1'b0, 3'h6);
    sleep_mode <= 1'b1;
    steps(11);
    repeat (8) @(posedge aclk);
    chk(pwr, 1'b0);
    rd(`ACS_IDX_CTRL0); chk(rd_v[1:0], 2'b01);
    sleep_mode <= 1'b0;
    rd(`ACS_IDX_RES_HI); chk(rd_v, 32'hca);
    $display("sleep done");
    wr(`ACS_IDX_CLK_SEL, 8'h10);
    start(1'b1, 1'b0, 3'h1);
    steps(2);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(pwr, 1'b0);
    rd(`ACS_IDX_RES_HI); chk(rd_v, 32'hca);
    n = nstep;
    wr(`ACS_IDX_CTRL0, 8'h02);
    repeat (20) @(posedge aclk);
    chk(nstep, n);
    rd(`ACS_IDX_CTRL0); chk(rd_v, 32'h0);
    $display("reset done");
    summarize();
  end
endmodule // tb
`default_nettype wire
